// File: dpm_pkg.sv
// Package with op codes, pin widths and timing counts for the dual-port memory controller
package dpm_pkg;
  // Clock period at 250 MHz
  localparam int CLK_NS = 4;
  // Pin geometry
  localparam int ADDR_W      = 14;
  localparam int DATA_W      = 16;
  localparam int FLAG_SEL_W  = 3;
  // Mailbox locations, right port owns the top word
  localparam logic [13:0] MBOX_RIGHT = 14'h3FFF;
  localparam logic [13:0] MBOX_LEFT  = 14'h3FFE;
  // Device times in ns, slowest grade
  localparam int SELECT_ACCESS_NS     = 20;
  localparam int OE_ACCESS_NS         = 12;
  localparam int WRITE_PULSE_NS       = 15;
  localparam int WRITE_SETUP_NS       = 15;
  localparam int BUSY_SETTLE_NS       = 20;
  localparam int FLOWTHROUGH_NS       = 30;
  localparam int FLAG_UPDATE_PULSE_NS = 10;
  localparam int FLAG_WR_TO_RD_NS     = 5;
  // Least times rounded up to whole cycles
  localparam int ACCESS_CYC  = ((SELECT_ACCESS_NS > OE_ACCESS_NS ? SELECT_ACCESS_NS : OE_ACCESS_NS)
                                + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC  = ((WRITE_PULSE_NS > WRITE_SETUP_NS ? WRITE_PULSE_NS : WRITE_SETUP_NS)
                                + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC  = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOW_CYC    = (FLOWTHROUGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLAG_GAP_CYC = ((FLAG_UPDATE_PULSE_NS > FLAG_WR_TO_RD_NS ? FLAG_UPDATE_PULSE_NS
                                 : FLAG_WR_TO_RD_NS) + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 8;
  // Command codes
  typedef enum logic [2:0] {
    DPM_OP_READ     = 3'h0,
    DPM_OP_WRITE    = 3'h1,
    DPM_OP_FLAG_RD  = 3'h2,
    DPM_OP_FLAG_WR  = 3'h3,
    DPM_OP_ACQUIRE  = 3'h4
  } dpm_op_t;
  // Sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    DPM_IDLE    = 3'b000,
    DPM_SETTLE  = 3'b001,
    DPM_STROBE  = 3'b011,
    DPM_RECOVER = 3'b010
  } dpm_state_t;
endpackage

// File: dpm_timer.sv
// Down-counting wait timer used for every pin phase
module dpm_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Load and status
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Loaded value is the number of cycles to wait; zero means expired
  always_comb
  begin
    cnt_d = cnt_q;
    if (load)
      cnt_d = count;
    else if (cnt_q != '0)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  // Expiry is held until the next load; not gated by load, which the user derives from done
  assign done = (cnt_q == '0);
endmodule

// File: dpm_port_ctrl.sv
// One-port bus controller that sequences array, mailbox and flag-latch accesses on a dual-port memory
module dpm_port_ctrl #(
  parameter int AW = dpm_pkg::ADDR_W,
  parameter int DW = dpm_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // Command side
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire dpm_pkg::dpm_op_t  cmd_op,
  input  wire logic [AW-1:0]     cmd_addr,
  input  wire logic [DW-1:0]     cmd_wdata,
  input  wire logic [1:0]        cmd_be,
  // Answer side
  output logic                   rsp_valid,
  output logic [DW-1:0]          rsp_rdata,
  output logic                   rsp_busy_seen,
  output logic                   rsp_owned,
  output logic                   mbox_irq,
  // Memory pins
  output logic [AW-1:0]          mem_addr,
  output logic                   mem_sel_n,
  output logic                   flag_latch_select_n,
  output logic                   mem_oe_n,
  output logic                   mem_we_n,
  output logic                   mem_ub_n,
  output logic                   mem_lb_n,
  input  wire logic [DW-1:0]     mem_dq_in,
  output logic [DW-1:0]          mem_dq_out,
  output logic                   mem_dq_oe_n,
  input  wire logic              mem_busy_n,
  input  wire logic              mem_int_n
);
  import dpm_pkg::*;

  dpm_state_t       state_q, state_d;
  dpm_op_t          op_q, op_d;
  logic [AW-1:0]    addr_q, addr_d;
  logic [DW-1:0]    wdata_q, wdata_d;
  logic [1:0]       be_q, be_d;
  logic             is_wr_q, is_wr_d;
  logic             is_flag_q, is_flag_d;
  logic             sel_n_q, sel_n_d;
  logic             flag_n_q, flag_n_d;
  logic             oe_n_q, oe_n_d;
  logic             we_n_q, we_n_d;
  logic             drive_n_q, drive_n_d;
  logic             busy_seen_q, busy_seen_d;
  logic             rsp_valid_q, rsp_valid_d;
  logic [DW-1:0]    rdata_q, rdata_d;
  logic             owned_q, owned_d;
  logic             irq_q;
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic             tmr_done;

  dpm_timer #(.W(TMR_W)) u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .load  (tmr_load),
    .count (tmr_count),
    .done  (tmr_done)
  );

  // Sequencer: select, settle, strobe, deselect, in that order per access
  always_comb
  begin
    state_d     = state_q;
    op_d        = op_q;
    addr_d      = addr_q;
    wdata_d     = wdata_q;
    be_d        = be_q;
    is_wr_d     = is_wr_q;
    is_flag_d   = is_flag_q;
    sel_n_d     = sel_n_q;
    flag_n_d    = flag_n_q;
    oe_n_d      = oe_n_q;
    we_n_d      = we_n_q;
    drive_n_d   = drive_n_q;
    busy_seen_d = busy_seen_q;
    rsp_valid_d = 1'b0;
    rdata_d     = rdata_q;
    owned_d     = owned_q;
    tmr_load    = 1'b0;
    tmr_count   = TMR_W'(1);
    case (state_q)
      DPM_IDLE:
      begin
        if (cmd_valid)
        begin
          op_d        = cmd_op;
          addr_d      = cmd_addr;
          be_d        = cmd_be;
          busy_seen_d = 1'b0;
          is_flag_d   = (cmd_op != DPM_OP_READ) && (cmd_op != DPM_OP_WRITE);
          is_wr_d     = (cmd_op == DPM_OP_WRITE) || (cmd_op == DPM_OP_FLAG_WR) || (cmd_op == DPM_OP_ACQUIRE);
          // Acquire always requests with a zero in bit 0
          wdata_d     = (cmd_op == DPM_OP_ACQUIRE) ? '0 : cmd_wdata;
          // Flag access keeps the array select high
          sel_n_d     = is_flag_d;
          flag_n_d    = !is_flag_d;
          drive_n_d   = !is_wr_d;
          we_n_d      = 1'b1;
          oe_n_d      = 1'b1;
          tmr_load    = 1'b1;
          // Give the busy line time to settle before any write strobe
          tmr_count   = TMR_W'(SETTLE_CYC);
          state_d     = DPM_SETTLE;
        end
      end
      DPM_SETTLE:
      begin
        if (tmr_done)
        begin
          if (is_wr_q && !is_flag_q && !mem_busy_n)
          begin
            // Contention: hold the write back until busy is released
            busy_seen_d = 1'b1;
            tmr_load    = 1'b1;
            tmr_count   = TMR_W'(SETTLE_CYC);
          end
          else if (is_wr_q)
          begin
            we_n_d    = 1'b0;
            tmr_load  = 1'b1;
            tmr_count = TMR_W'(STROBE_CYC);
            state_d   = DPM_STROBE;
          end
          else
          begin
            // Both select and output enable low for a read
            oe_n_d    = 1'b0;
            tmr_load  = 1'b1;
            tmr_count = TMR_W'(ACCESS_CYC);
            state_d   = DPM_STROBE;
          end
        end
      end
      DPM_STROBE:
      begin
        if (!is_wr_q && !is_flag_q && !mem_busy_n)
        begin
          // Lost arbitration: data is only stable a flowthrough after release
          busy_seen_d = 1'b1;
          tmr_load    = 1'b1;
          tmr_count   = TMR_W'(FLOW_CYC);
        end
        else if (tmr_done)
        begin
          // Strobe rises while data is still driven; data drops next phase
          we_n_d   = 1'b1;
          oe_n_d   = 1'b1;
          sel_n_d  = 1'b1;
          flag_n_d = 1'b1;
          if (!is_wr_q)
          begin
            rdata_d = mem_dq_in;
            // Flag value appears on every line; bit 0 is enough
            owned_d = !mem_dq_in[0];
          end
          tmr_load  = 1'b1;
          // Deselect gap also covers the flag write-to-read time
          tmr_count = is_flag_q ? TMR_W'(FLAG_GAP_CYC) : TMR_W'(1);
          state_d   = DPM_RECOVER;
        end
      end
      DPM_RECOVER:
      begin
        drive_n_d = 1'b1;
        if (tmr_done)
        begin
          if (op_q == DPM_OP_ACQUIRE && (is_wr_q || !owned_q))
          begin
            // Read back after the request; keep polling while the other side owns it
            is_wr_d   = 1'b0;
            flag_n_d  = 1'b0;
            tmr_load  = 1'b1;
            tmr_count = TMR_W'(SETTLE_CYC);
            state_d   = DPM_SETTLE;
          end
          else
          begin
            rsp_valid_d = 1'b1;
            state_d     = DPM_IDLE;
          end
        end
      end
      default:
        state_d = DPM_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q     <= DPM_IDLE;
      op_q        <= DPM_OP_READ;
      addr_q      <= '0;
      wdata_q     <= '0;
      be_q        <= 2'h0;
      is_wr_q     <= 1'b0;
      is_flag_q   <= 1'b0;
      sel_n_q     <= 1'b1;
      flag_n_q    <= 1'b1;
      oe_n_q      <= 1'b1;
      we_n_q      <= 1'b1;
      drive_n_q   <= 1'b1;
      busy_seen_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q     <= '0;
      owned_q     <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      op_q        <= op_d;
      addr_q      <= addr_d;
      wdata_q     <= wdata_d;
      be_q        <= be_d;
      is_wr_q     <= is_wr_d;
      is_flag_q   <= is_flag_d;
      sel_n_q     <= sel_n_d;
      flag_n_q    <= flag_n_d;
      oe_n_q      <= oe_n_d;
      we_n_q      <= we_n_d;
      drive_n_q   <= drive_n_d;
      busy_seen_q <= busy_seen_d;
      rsp_valid_q <= rsp_valid_d;
      rdata_q     <= rdata_d;
      owned_q     <= owned_d;
    end
  end

  // Interrupt pin registered so the user side sees a clean level
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= !mem_int_n;
  end

  // Flag accesses force both byte lanes high; only the low address bits matter there
  assign mem_ub_n            = !(be_q[1] && !is_flag_q);
  assign mem_lb_n            = !(be_q[0] && !is_flag_q);
  assign mem_addr            = is_flag_q ? {{(AW-FLAG_SEL_W){1'b0}}, addr_q[FLAG_SEL_W-1:0]} : addr_q;
  assign mem_sel_n           = sel_n_q;
  assign flag_latch_select_n = flag_n_q;
  assign mem_oe_n            = oe_n_q;
  assign mem_we_n            = we_n_q;
  assign mem_dq_out          = wdata_q;
  assign mem_dq_oe_n         = drive_n_q;
  assign cmd_ready           = (state_q == DPM_IDLE);
  assign rsp_valid           = rsp_valid_q;
  assign rsp_rdata           = rdata_q;
  assign rsp_busy_seen       = busy_seen_q;
  assign rsp_owned           = owned_q;
  assign mbox_irq            = irq_q;
endmodule

// File: dpm_port_ctrl_properties.sv
// Pin timing checks for the one-port dual-port memory controller
module dpm_port_ctrl_properties
  import dpm_pkg::*;
(
  // Clock and reset
  input wire logic                       mclk,
  input wire logic                       rst,
  // Command side
  input wire logic                       cmd_ready,
  input wire logic                       rsp_valid,
  // Memory pins
  input wire logic [dpm_pkg::ADDR_W-1:0] mem_addr,
  input wire logic                       mem_sel_n,
  input wire logic                       flag_latch_select_n,
  input wire logic                       mem_oe_n,
  input wire logic                       mem_we_n,
  input wire logic                       mem_ub_n,
  input wire logic                       mem_lb_n,
  input wire logic [dpm_pkg::DATA_W-1:0] mem_dq_out,
  input wire logic                       mem_dq_oe_n,
  input wire logic                       mem_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Strobe low with data driven and steady, then data kept one cycle past the rise
  sequence wr_pulse;
    (!mem_we_n && !mem_dq_oe_n && $stable(mem_dq_out))[*5];
  endsequence
  sequence data_held;
    mem_we_n && !mem_dq_oe_n && $stable(mem_dq_out);
  endsequence

  chk_write_pulse_len: assert property ($fell(mem_we_n) |-> wr_pulse ##1 data_held)
    else $error("write strobe width or data hold wrong");
  chk_settle_first: assert property ($fell(mem_we_n) |->
                                     !$past(mem_sel_n, 5) || !$past(flag_latch_select_n, 5))
    else $error("write started before busy settle time");
  chk_busy_blocks_write: assert property ($fell(mem_we_n) && !mem_sel_n |-> $past(mem_busy_n))
    else $error("array write started while busy low");
  chk_read_select: assert property (!mem_oe_n |-> mem_we_n && (!mem_sel_n || !flag_latch_select_n))
    else $error("output enable without a select");
  chk_read_access: assert property ($fell(mem_oe_n) |-> !mem_oe_n[*5])
    else $error("read ended before access time");
  chk_flag_apart: assert property (!flag_latch_select_n |-> mem_sel_n && mem_ub_n && mem_lb_n
                                   && mem_addr[ADDR_W-1:3] == '0)
    else $error("flag access with array select or lanes");
  chk_flag_gap: assert property ($rose(flag_latch_select_n) && !$past(mem_we_n) |-> flag_latch_select_n[*3])
    else $error("flag read too soon after flag write");
  chk_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer pulse longer than one cycle");
  chk_idle_pins: assert property (cmd_ready |-> mem_sel_n && flag_latch_select_n && mem_we_n && mem_dq_oe_n)
    else $error("pins active while idle");
endmodule

bind dpm_port_ctrl dpm_port_ctrl_properties u_chk (.mclk, .rst, .cmd_ready, .rsp_valid, .mem_addr, .mem_sel_n,
  .flag_latch_select_n, .mem_oe_n, .mem_we_n, .mem_ub_n, .mem_lb_n, .mem_dq_out, .mem_dq_oe_n, .mem_busy_n);

// File: dpm_dev_model.sv
// Behavioural left device port: array, mailboxes and flag latches, far port driven by tasks
module dpm_dev_model
  import dpm_pkg::*;
(
  // Sampling clock
  input  wire logic                       mclk,
  // Controller pins
  input  wire logic [dpm_pkg::ADDR_W-1:0] addr,
  input  wire logic                       sel_n,
  input  wire logic                       flg_n,
  input  wire logic                       oe_n,
  input  wire logic                       we_n,
  input  wire logic                       ub_n,
  input  wire logic                       lb_n,
  input  wire logic [dpm_pkg::DATA_W-1:0] d,
  // Busy from the master device, low means this port lost
  input  wire logic                       busy_n,
  // Answers
  output logic [dpm_pkg::DATA_W-1:0]      q,
  output logic                            int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [7:0]        own [2];   // Token holders: 0 this port, 1 far port
  logic [7:0]        req [2];   // Waiting requests
  logic              rint_n;    // Far port interrupt
  logic              fl_q;      // Frozen flag read value
  logic [DATA_W-1:0] last_q;

  // All tokens free at start
  initial
  begin
    own[0] = '0;
    own[1] = '0;
    req[0] = '0;
    req[1] = '0;
    int_n = 1'b1;
    rint_n = 1'b1;
    last_q = '0;
  end

  // Token write from side s; only bit 0 of the data counts
  task automatic fl_wr(input int s, input int i, input logic v);
    if (!v && !own[1-s][i]) own[s][i] = 1'b1;
    else if (!v) req[s][i] = 1'b1;
    else if (own[s][i])
    begin
      own[s][i] = 1'b0;
      own[1-s][i] = req[1-s][i];
      req[1-s][i] = 1'b0;
    end
    else req[s][i] = 1'b0;
  endtask

  // Far port array write; its write to our mailbox raises our interrupt
  task automatic far_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    mem[a] = v;
    if (a == MBOX_LEFT) int_n = 1'b0;
  endtask

  // Level sampled writes; repeating a commit is harmless, which keeps the model simple
  always @(posedge mclk)
  begin
    if (!we_n && !sel_n && busy_n)
    begin
      if (!ub_n) mem[addr][15:8] = d[15:8];
      if (!lb_n) mem[addr][7:0] = d[7:0];
      if (addr == MBOX_RIGHT) rint_n <= 1'b0;
    end
    if (!we_n && !flg_n && sel_n) fl_wr(0, addr[2:0], d[0]);
    if (!oe_n && we_n && !sel_n && busy_n && addr == MBOX_LEFT) int_n <= 1'b1;
    if (!flg_n && oe_n) fl_q = ~own[0][addr[2:0]];
    if (!oe_n) last_q = q;
  end

  // Released bus shows the inverse of the last value, never a stale copy
  always_comb
    if (!oe_n && we_n && !sel_n) q = mem[addr];
    else if (!oe_n && we_n && !flg_n) q = {DATA_W{fl_q}};
    else q = ~last_q;
endmodule

// File: dpm_port_ctrl_tb.sv
// Self-checking bench for the one-port controller against the device model
module dpm_port_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, busy_n = 1'b1;
  dpm_op_t cmd_op = DPM_OP_READ;
  logic [ADDR_W-1:0] cmd_addr = '0, mem_addr;
  logic [DATA_W-1:0] cmd_wdata = '0, rsp_rdata, mem_dq_in, mem_dq_out;
  logic [1:0] cmd_be = 2'h3;
  logic cmd_ready, rsp_valid, rsp_busy_seen, rsp_owned, mbox_irq, mem_sel_n, flag_latch_select_n;
  logic mem_oe_n, mem_we_n, mem_ub_n, mem_lb_n, mem_dq_oe_n, mem_int_n;
  int error_cnt = 0, total_checks = 0;

  dpm_port_ctrl uut (.mclk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_be,
    .rsp_valid, .rsp_rdata, .rsp_busy_seen, .rsp_owned, .mbox_irq, .mem_addr, .mem_sel_n,
    .flag_latch_select_n, .mem_oe_n, .mem_we_n, .mem_ub_n, .mem_lb_n, .mem_dq_in, .mem_dq_out,
    .mem_dq_oe_n, .mem_busy_n(busy_n), .mem_int_n);
  dpm_dev_model dev (.mclk, .addr(mem_addr), .sel_n(mem_sel_n), .flg_n(flag_latch_select_n),
    .oe_n(mem_oe_n), .we_n(mem_we_n), .ub_n(mem_ub_n), .lb_n(mem_lb_n), .d(mem_dq_out),
    .busy_n, .q(mem_dq_in), .int_n(mem_int_n));

  // 250 MHz clock
  initial forever #2 mclk = ~mclk;

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One command, held one edge, then wait for its answer under a bound
  task automatic run(input dpm_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    int n;
    n = 0;
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= v;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    chk(n < 2000, 1'b1);
  endtask

  task automatic t_start;
    @(negedge mclk);
    chk(mbox_irq, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      run(DPM_OP_FLAG_RD, ADDR_W'(i), '0);
      chk(rsp_rdata, 16'hFFFF);
    end
  endtask

  task automatic t_array;
    run(DPM_OP_WRITE, 14'h0123, 16'hA5C3);
    @(posedge mclk);
    cmd_be <= 2'h1;
    run(DPM_OP_WRITE, 14'h0123, 16'h1100);
    @(posedge mclk);
    cmd_be <= 2'h3;
    run(DPM_OP_READ, 14'h0123, '0);
    chk(rsp_rdata, 16'hA500);
  endtask

  // Mailbox interrupt set by far port, kept by reads elsewhere or under busy
  task automatic t_mbox;
    dev.far_wr(MBOX_LEFT, 16'h5A5A);
    repeat (2) @(negedge mclk);
    chk(mbox_irq, 1'b1);
    run(DPM_OP_READ, MBOX_RIGHT, '0);
    chk(mbox_irq, 1'b1);
    fork
      run(DPM_OP_READ, MBOX_LEFT, '0);
      begin
        @(posedge mclk);
        busy_n <= 1'b0;
        repeat (30) @(negedge mclk);
        chk(mbox_irq, 1'b1);
        @(posedge mclk);
        busy_n <= 1'b1;
      end
    join
    chk(rsp_rdata, 16'h5A5A);
    chk(rsp_busy_seen, 1'b1);
    repeat (2) @(negedge mclk);
    chk(mbox_irq, 1'b0);
  endtask

  // Write to far mailbox held off by busy
  task automatic t_mbox_wr;
    fork
      run(DPM_OP_WRITE, MBOX_RIGHT, 16'h0F0F);
      begin
        @(posedge mclk);
        busy_n <= 1'b0;
        repeat (40) @(negedge mclk);
        chk(dev.rint_n, 1'b1);
        @(posedge mclk);
        busy_n <= 1'b1;
      end
    join
    chk(dev.rint_n, 1'b0);
    chk(dev.mem[MBOX_RIGHT], 16'h0F0F);
    chk(rsp_busy_seen, 1'b1);
  endtask

  // Token hand-over between ports
  task automatic t_flag;
    run(DPM_OP_ACQUIRE, 14'h3FFA, '0);
    chk(rsp_owned, 1'b1);
    chk(dev.own[1][2], 1'b0);
    dev.fl_wr(1, 2, 1'b0);
    run(DPM_OP_FLAG_RD, 14'h0002, '0);
    chk(rsp_rdata, 16'h0000);
    run(DPM_OP_FLAG_WR, 14'h0002, 16'h0001);
    chk(dev.own[1][2], 1'b1);
    fork
      run(DPM_OP_ACQUIRE, 14'h0002, '0);
      begin
        repeat (60) @(negedge mclk);
        dev.fl_wr(1, 2, 1'b1);
      end
    join
    chk(rsp_owned, 1'b1);
    run(DPM_OP_FLAG_WR, 14'h0005, 16'hFFFE);
    chk(dev.own[0][5], 1'b1);
    run(DPM_OP_FLAG_WR, 14'h0002, 16'hFFFF);
    run(DPM_OP_FLAG_RD, 14'h0002, '0);
    chk(rsp_rdata, 16'hFFFF);
  endtask

  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_start;
    t_array;
    t_mbox;
    t_mbox_wr;
    t_flag;
    wrap_up;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    wrap_up;
  end
endmodule
